// File: src/timer_b_pair.sv
// type b timer pair: even and odd channel with apb control
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "timer_b_params.svh"
module timer_b_pair
  import timer_b_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_mode,
  input  wire logic        even_ext_clk,
  input  wire logic        odd_ext_clk,
  input  wire logic        even_gate,
  input  wire logic        odd_gate,
  output logic [31:0]      count_q,
  output logic             pair_q
);
  tb_ctrl_t   even_q;
  tb_ctrl_t   odd_q;
  tb_ctrl_t   even_eff;
  tb_ctrl_t   odd_eff;
  logic [31:0] period_q;
  logic        even_tick;
  logic        odd_tick;
  logic        wr;
  logic        rd;
  logic [31:0] rd_d;
  logic        err_d;
  logic        wrap_lo;
  logic        wrap_hi;

  function automatic tb_ctrl_t unpack_ctrl(input logic [31:0] w, input logic even);
    tb_ctrl_t c;
    c.on                      = w[`TB_ON_BIT];
    c.stop_in_idle            = w[`TB_STOP_IN_IDLE_BIT];
    c.gated_accumulate_enable = w[`TB_GATE_BIT];
    c.input_prescale_select   = w[`TB_PS_LSB+2:`TB_PS_LSB];
    // pairing bit only on even channel
    c.pair_wide_mode          = even & w[`TB_PAIR_BIT];
    c.clock_source_select     = w[`TB_CS_BIT];
    unpack_ctrl = c;
  endfunction

  function automatic logic [31:0] pack_ctrl(input tb_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`TB_ON_BIT]   = c.on;
    w[`TB_STOP_IN_IDLE_BIT] = c.stop_in_idle;
    // gate reads zero with external source
    w[`TB_GATE_BIT] = c.gated_accumulate_enable & ~c.clock_source_select;
    w[`TB_PS_LSB+2:`TB_PS_LSB] = c.input_prescale_select;
    w[`TB_PAIR_BIT] = c.pair_wide_mode;
    w[`TB_CS_BIT]   = c.clock_source_select;
    pack_ctrl = w;
  endfunction

  // zero-wait slave: access phase completes at once
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      even_q <= tb_ctrl_t'(`TB_CTRL_RESET);
      odd_q  <= tb_ctrl_t'(`TB_CTRL_RESET);
    end
    else if (wr)
    begin
      if (paddr == `TB_EVEN_CTRL_OFS)
        even_q <= unpack_ctrl(pwdata, 1'b1);
      else if (paddr == `TB_ODD_CTRL_OFS)
        odd_q <= unpack_ctrl(pwdata, 1'b0);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period_q <= 32'hffff_ffff;
    else if (wr && paddr == `TB_PERIOD_OFS)
      period_q <= pwdata;
  end

  always_comb
  begin
    even_eff = even_q;
    even_eff.gated_accumulate_enable = even_q.gated_accumulate_enable & ~even_q.clock_source_select;
    odd_eff = odd_q;
    odd_eff.gated_accumulate_enable = odd_q.gated_accumulate_enable & ~odd_q.clock_source_select;
    // paired mode: odd settings except idle bit replaced by even's
    // odd idle bit still halts the whole paired count
    if (even_q.pair_wide_mode)
    begin
      odd_eff = even_eff;
      odd_eff.stop_in_idle = odd_q.stop_in_idle;
    end
  end

  timer_b_unit u_even (
    .pclk      (pclk),
    .presetn   (presetn),
    .cfg       (even_eff),
    .idle_mode (idle_mode),
    .ext_clk   (even_ext_clk),
    .gate_in   (even_gate),
    .tick      (even_tick)
  );

  timer_b_unit u_odd (
    .pclk      (pclk),
    .presetn   (presetn),
    .cfg       (odd_eff),
    .idle_mode (idle_mode),
    .ext_clk   (odd_ext_clk),
    .gate_in   (odd_gate),
    .tick      (odd_tick)
  );

  assign wrap_lo = (count_q[15:0] == period_q[15:0]);
  assign wrap_hi = (count_q[31:16] == period_q[31:16]);

  // paired 32-bit count and independent halves
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= 32'h0000_0000;
    else if (wr && paddr == `TB_EVEN_COUNT_OFS)
      count_q[15:0] <= pwdata[15:0];
    else if (wr && paddr == `TB_ODD_COUNT_OFS)
      count_q[31:16] <= pwdata[15:0];
    else if (even_q.pair_wide_mode)
    begin
      // paired count also needs the odd idle bit clear to advance in idle mode
      if (even_tick && !(odd_q.stop_in_idle && idle_mode))
      begin
        if (wrap_lo && wrap_hi)
          count_q <= 32'h0000_0000;
        else
          count_q <= count_q + 32'h0000_0001;
      end
    end
    else
    begin
      if (even_tick)
        count_q[15:0] <= wrap_lo ? 16'h0000 : count_q[15:0] + 16'h0001;
      if (odd_tick)
        count_q[31:16] <= wrap_hi ? 16'h0000 : count_q[31:16] + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pair_q <= 1'b0;
    else
      pair_q <= even_q.pair_wide_mode;
  end

  always_comb
  begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `TB_EVEN_CTRL_OFS)
      rd_d = pack_ctrl(even_q) & `TB_EVEN_MASK;
    else if (paddr == `TB_ODD_CTRL_OFS)
      rd_d = pack_ctrl(odd_q) & `TB_ODD_MASK;
    else if (paddr == `TB_EVEN_COUNT_OFS)
      rd_d = {16'h0000, count_q[15:0]};
    else if (paddr == `TB_ODD_COUNT_OFS)
      rd_d = {16'h0000, count_q[31:16]};
    else if (paddr == `TB_PERIOD_OFS)
      rd_d = period_q;
    else
      err_d = 1'b1;
  end

  // registered answer; pready high one cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & err_d;
      if (psel && !penable && !pwrite)
        prdata <= rd_d;
    end
  end

  off_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!even_q.on && !even_q.pair_wide_mode && !wr) |=> $stable(count_q[15:0]))
    else $error("even half moved while disabled");
  idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (idle_mode && even_q.stop_in_idle) |-> !even_tick)
    else $error("tick while stopped in idle");
  gate_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && paddr == `TB_EVEN_CTRL_OFS && even_q.clock_source_select) |-> !prdata[`TB_GATE_BIT])
    else $error("gate bit read nonzero");
  gate_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (even_eff.gated_accumulate_enable && !even_gate) |-> !even_tick)
    else $error("tick with gate low");
  // divide by two spacing, config rewrite excluded
  div_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (even_tick && even_q.input_prescale_select == 3'h1 && !even_q.clock_source_select && !wr) |=> !even_tick)
    else $error("prescale two ticks back to back");
  pair_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (even_q.pair_wide_mode && even_tick && !idle_mode && count_q[15:0] == 16'hffff && !wrap_lo && !wr)
    |=> count_q[31:16] == $past(count_q[31:16]) + 16'h0001)
    else $error("no carry in paired mode");
  odd_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    !odd_q.pair_wide_mode)
    else $error("odd pairing bit set");
  upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && (paddr == `TB_EVEN_CTRL_OFS || paddr == `TB_ODD_CTRL_OFS)) |-> prdata[31:16] == 16'h0000)
    else $error("upper control bits nonzero");
  // paired count moves only on even ticks
  odd_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (even_q.pair_wide_mode && !even_tick && !wr) |=> $stable(count_q))
    else $error("paired count moved without even tick");

  pair_cov_c: cover property (@(posedge pclk) disable iff (!presetn) even_q.pair_wide_mode && even_tick);
  gate_cov_c: cover property (@(posedge pclk) disable iff (!presetn) even_eff.gated_accumulate_enable && even_tick);
  ps256_cov_c: cover property (@(posedge pclk) disable iff (!presetn) even_q.input_prescale_select == 3'h7 && even_tick);
  odd_cov_c: cover property (@(posedge pclk) disable iff (!presetn) !even_q.pair_wide_mode && odd_tick);
endmodule

// File: src/timer_b_params.svh
// constants for the type b timer pair block
`ifndef TIMER_B_PARAMS_SVH
`define TIMER_B_PARAMS_SVH
`define TB_EVEN_CTRL_OFS   12'h000
`define TB_ODD_CTRL_OFS    12'h010
`define TB_EVEN_COUNT_OFS  12'h020
`define TB_ODD_COUNT_OFS   12'h030
`define TB_PERIOD_OFS      12'h040
`define TB_ON_BIT          15
`define TB_STOP_IN_IDLE_BIT        13
`define TB_GATE_BIT        7
`define TB_PS_LSB          4
`define TB_PAIR_BIT        3
`define TB_CS_BIT          1
`define TB_EVEN_MASK       32'h0000_a0fa
`define TB_ODD_MASK        32'h0000_a0f2
`define TB_CTRL_RESET      8'h00
`endif

// File: src/timer_b_pkg.sv
// types for the type b timer pair block
package timer_b_pkg;
  typedef struct packed {
    logic       on;
    logic       stop_in_idle;
    logic       gated_accumulate_enable;
    logic [2:0] input_prescale_select;
    logic       pair_wide_mode;
    logic       clock_source_select;
  } tb_ctrl_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01
  } apb_state_t;
endpackage

// File: src/timer_b_unit.sv
// one timer channel: tick generation with prescale and gating
`timescale 1ns/1ps
`include "timer_b_params.svh"
module timer_b_unit
  import timer_b_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire tb_ctrl_t cfg,
  input  wire logic     idle_mode,
  input  wire logic     ext_clk,
  input  wire logic     gate_in,
  output logic          tick
);
  logic [7:0] ps_cnt_q;
  logic       ext_q;
  logic       src_edge;
  logic       run;
  logic       last;

  // prescale code to terminal count
  function automatic logic [7:0] ps_limit(input logic [2:0] code);
    if (code == 3'h7)
      ps_limit = 8'hff;
    else
      ps_limit = 8'((9'h1 << code) - 9'h1);
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_q <= 1'b0;
    else
      ext_q <= ext_clk;
  end

  assign src_edge = cfg.clock_source_select ? (ext_clk & ~ext_q) : 1'b1;
  assign run = cfg.on & ~(cfg.stop_in_idle & idle_mode);
  assign last = (ps_cnt_q == ps_limit(cfg.input_prescale_select));

  // gating counts only while gate high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ps_cnt_q <= 8'h00;
    else if (!run)
      ps_cnt_q <= 8'h00;
    else if (src_edge && (!cfg.gated_accumulate_enable || gate_in))
    begin
      if (last)
        ps_cnt_q <= 8'h00;
      else
        ps_cnt_q <= ps_cnt_q + 8'h01;
    end
  end

  assign tick = run & src_edge & (!cfg.gated_accumulate_enable | gate_in) & last;
endmodule

// File: tb/type_b_timer_control_tb.sv
// self-checking bench for the type b timer pair
`timescale 1ns/1ps
`include "timer_b_params.svh"
module type_b_timer_control_tb;
  localparam logic [31:0] ON_B = 32'h1 << `TB_ON_BIT;
  localparam logic [31:0] IDL_B = 32'h1 << `TB_STOP_IN_IDLE_BIT;
  localparam logic [31:0] GT_B = 32'h1 << `TB_GATE_BIT;
  localparam logic [31:0] PR_B = 32'h1 << `TB_PAIR_BIT;
  localparam logic [31:0] CS_B = 32'h1 << `TB_CS_BIT;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic        idle_mode = 1'b0;
  logic        even_ext_clk = 1'b0;
  logic        even_gate = 1'b0;
  logic        odd_ext_clk = 1'b0;
  logic        odd_gate = 1'b0;
  logic [31:0] prdata;
  logic [31:0] count_q;
  logic        pready;
  logic        pslverr;
  logic        pair_q;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] v;
  logic [31:0] d;
  logic [8:0]  ratio [8] = '{9'h1, 9'h2, 9'h4, 9'h8, 9'h10, 9'h20, 9'h40, 9'h100};
  int          n_mismatch = 0;
  int          n_compared = 0;

  timer_b_pair dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .even_ext_clk(even_ext_clk), .odd_ext_clk(odd_ext_clk),
    .even_gate(even_gate), .odd_gate(odd_gate), .count_q(count_q), .pair_q(pair_q));

  initial
    forever #12.5 pclk = ~pclk;

  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // counts may land up to tol ticks either side of the window
  task near(input string nm, input logic [31:0] dd, input logic [31:0] ex, input logic [31:0] tol);
    check(nm, (dd + tol >= ex && dd <= ex + tol) ? ex : dd, ex);
  endtask

  function automatic logic [31:0] ctl(input logic [31:0] w, input logic [31:0] m);
    ctl = w & m;
    if (w[`TB_CS_BIT])
      ctl[`TB_GATE_BIT] = 1'b0;
  endfunction

  // one transfer; expected result queued for the monitor
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] ex);
    exp_q.push_back({~w, a[8], ex});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog may end a hung wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task meas(input int g, output logic [31:0] dd);
    logic [31:0] a0;
    @(negedge pclk);
    a0 = count_q;
    repeat (g) @(negedge pclk);
    dd = count_q - a0;
    @(posedge pclk);
  endtask

  task pulses;
    repeat (6)
    begin
      even_ext_clk <= 1'b1;
      odd_ext_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      even_ext_clk <= 1'b0;
      odd_ext_clk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (e[33])
        check("prdata", prdata, e[31:0]);
    end

  task end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("timeout waiting for tests");
    end_sim;
  end

  initial
  begin
    void'($urandom(32'h58e65543));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TB_EVEN_CTRL_OFS, 0, 0);
    apb(1'b0, `TB_ODD_CTRL_OFS, 0, 0);
    check("pair_q", {31'h0, pair_q}, 32'h0);
    repeat (8)
    begin
      v = $urandom;
      apb(1'b1, `TB_EVEN_CTRL_OFS, v, 0);
      apb(1'b0, `TB_EVEN_CTRL_OFS, 0, ctl(v, `TB_EVEN_MASK));
      apb(1'b1, `TB_ODD_CTRL_OFS, v, 0);
      apb(1'b0, `TB_ODD_CTRL_OFS, 0, ctl(v, `TB_ODD_MASK));
    end
    check("pair_q", {31'h0, pair_q}, {31'h0, v[`TB_PAIR_BIT]});
    apb(1'b1, 12'h100, $urandom, 0);
    apb(1'b0, 12'h100, 0, 0);
    apb(1'b1, `TB_ODD_CTRL_OFS, 0, 0);
    apb(1'b1, `TB_ODD_COUNT_OFS, 0, 0);
    apb(1'b1, `TB_PERIOD_OFS, 32'hffff_ffff, 0);
    apb(1'b1, `TB_EVEN_COUNT_OFS, 0, 0);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, `TB_EVEN_CTRL_OFS, ON_B | (k << `TB_PS_LSB), 0);
      meas(512, d);
      near("even_count", {16'h0, d[15:0]}, 32'h200 / ratio[k], 1);
    end
    apb(1'b1, `TB_EVEN_CTRL_OFS, 0, 0);
    meas(64, d);
    near("even_count", d, 0, 0);
    idle_mode <= 1'b1;
    apb(1'b1, `TB_EVEN_CTRL_OFS, ON_B | IDL_B, 0);
    meas(64, d);
    near("even_count", d, 0, 0);
    apb(1'b1, `TB_EVEN_CTRL_OFS, ON_B, 0);
    meas(64, d);
    near("even_count", {16'h0, d[15:0]}, 64, 1);
    idle_mode <= 1'b0;
    apb(1'b1, `TB_EVEN_CTRL_OFS, ON_B | GT_B, 0);
    meas(64, d);
    near("even_count", d, 0, 0);
    even_gate <= 1'b1;
    meas(64, d);
    near("even_count", {16'h0, d[15:0]}, 64, 1);
    even_gate <= 1'b0;
    apb(1'b1, `TB_ODD_CTRL_OFS, ON_B | GT_B | CS_B, 0);
    apb(1'b1, `TB_EVEN_CTRL_OFS, ON_B | GT_B | CS_B, 0);
    fork
      meas(64, d);
      pulses;
    join
    near("even_count", {16'h0, d[15:0]}, 6, 1);
    near("odd_count", {16'h0, d[31:16]}, 6, 1);
    apb(1'b1, `TB_ODD_CTRL_OFS, 0, 0);
    apb(1'b1, `TB_ODD_COUNT_OFS, 0, 0);
    apb(1'b1, `TB_EVEN_COUNT_OFS, 32'hfff0, 0);
    apb(1'b1, `TB_EVEN_CTRL_OFS, ON_B, 0);
    meas(64, d);
    check("odd_count", {16'h0, count_q[31:16]}, 0);
    // odd half alone: gated, divide by two
    apb(1'b1, `TB_ODD_CTRL_OFS, ON_B | GT_B | (32'h1 << `TB_PS_LSB), 0);
    odd_gate <= 1'b1;
    meas(64, d);
    near("odd_count", {16'h0, d[31:16]}, 32, 1);
    near("even_count", {16'h0, d[15:0]}, 64, 1);
    odd_gate <= 1'b0;
    apb(1'b1, `TB_ODD_CTRL_OFS, IDL_B, 0);
    apb(1'b1, `TB_EVEN_COUNT_OFS, 32'hfff0, 0);
    apb(1'b1, `TB_EVEN_CTRL_OFS, ON_B | PR_B, 0);
    // pair_q settles one edge after the write lands
    @(negedge pclk);
    check("pair_q", {31'h0, pair_q}, 32'h1);
    meas(64, d);
    near("pair_count", d, 64, 1);
    idle_mode <= 1'b1;
    meas(64, d);
    near("pair_count", d, 0, 0);
    // odd idle bit cleared so the pair runs
    apb(1'b1, `TB_ODD_CTRL_OFS, 0, 0);
    meas(64, d);
    near("pair_count", d, 64, 1);
    end_sim;
  end
endmodule
